// File: inc/cmp_pkg.sv
// Shared constants and types for the cache and translation RAM power gate.
package cmp_pkg;

  // ----------------------------------------------------------------------
  // Array indices and sizes.
  // ----------------------------------------------------------------------
  localparam int unsigned NARR = 3;
  localparam int unsigned ARR_ICACHE = 0;
  localparam int unsigned ARR_DCACHE = 1;
  localparam int unsigned ARR_XLATE = 2;
  localparam int unsigned AW = 5;
  localparam int unsigned DW = 32;

  // ----------------------------------------------------------------------
  // Register offsets of the controller.
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PWR = 5'h04;
  localparam logic [4:0] OFS_MAINT = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_REFUSE = 5'h10;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int unsigned MAINT_INV_BIT = 3;
  localparam int unsigned STAT_PWR_LSB = 0;
  localparam int unsigned STAT_EN_LSB = 4;
  localparam int unsigned STAT_EMPTY_LSB = 8;
  localparam int unsigned REF_EN_LSB = 0;
  localparam int unsigned REF_MAINT_LSB = 4;
  localparam int unsigned REF_OFF_LSB = 8;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [2:0] PWR_RST = 3'h7;

  // ----------------------------------------------------------------------
  // Power switch state of one RAM group.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_UP = 2'b01,
    PS_ON = 2'b10,
    PS_DOWN = 2'b11
  } cmp_ps_t;

endpackage

// File: inc/cmp_if.sv
// Link between the memory system end and the power control end.
`timescale 1ns/100ps
interface cmp_if;
  import cmp_pkg::*;

  logic c1_wr;
  logic [2:0] c1_en;
  logic [2:0] mnt_req;
  logic mnt_inv;
  logic [2:0] ram_pwr;
  logic [2:0] en;
  logic [2:0] empty;
  logic [2:0] mnt_ack;

  modport dev (
    input c1_wr, c1_en, mnt_req, mnt_inv, ram_pwr,
    output en, empty, mnt_ack
  );

  modport ctl (
    output c1_wr, c1_en, mnt_req, mnt_inv, ram_pwr,
    input en, empty, mnt_ack
  );
endinterface

// File: verilog/cmp_dev.sv
// Memory system end: enables, valid tracking and RAM access gating.
`timescale 1ns/100ps
module cmp_dev
  import cmp_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rstn_i,
  // Link to the power control end.
  cmp_if.dev lnk,
  // Memory system user side.
  input wire logic [2:0] lookup_i,
  input wire logic [2:0] fill_i,
  input wire logic [2:0] fault_clr_i,
  output logic [2:0] ram_cs_o,
  output logic [2:0] ram_pwr_o,
  output logic [2:0] en_o,
  output logic [2:0] fault_o
);

  typedef struct packed {
    logic [2:0] en;
    logic [2:0] valid;
    logic [2:0] cs;
    logic [2:0] pwr;
    logic [2:0] ack;
    logic [2:0] fault;
  } cmp_dev_t;

  cmp_dev_t st_r;
  cmp_dev_t st_nxt;

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NARR; i++) begin
      if (lnk.c1_wr) begin
        st_nxt.en[i] = lnk.c1_en[i];
      end
      if (lnk.mnt_req[i] && lnk.mnt_inv && lnk.ram_pwr[i]) begin
        st_nxt.valid[i] = 1'b0;
      end else if (fill_i[i] && st_r.en[i] && lnk.ram_pwr[i]) begin
        st_nxt.valid[i] = 1'b1;
      end
      st_nxt.cs[i] = lnk.ram_pwr[i] &
                     ((st_r.en[i] & (lookup_i[i] | fill_i[i])) | lnk.mnt_req[i]);
      st_nxt.pwr[i] = lnk.ram_pwr[i];
      st_nxt.ack[i] = lnk.mnt_req[i] & lnk.ram_pwr[i];
      if ((lnk.mnt_req[i] || (lnk.c1_wr && lnk.c1_en[i])) && !lnk.ram_pwr[i]) begin
        st_nxt.fault[i] = 1'b1;
      end else if (fault_clr_i[i]) begin
        st_nxt.fault[i] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.en = st_r.en;
  assign lnk.empty = ~st_r.valid;
  assign lnk.mnt_ack = st_r.ack;
  assign ram_cs_o = st_r.cs;
  assign ram_pwr_o = st_r.pwr;
  assign en_o = st_r.en;
  assign fault_o = st_r.fault;

endmodule

// File: verilog/cmp_pwr.sv
// Power control end: register port, power switch sequencing, request screening.
// Functional notes
// - cache RAM off only if disabled and empty.
// - disabled cache RAM accessed only by maintenance.
// - no cache maintenance while its RAM off.
// - restore cache RAM power before enabling cache.
// - translation RAM off only if disabled, empty.
// - disabled translation RAM accessed only by maintenance.
// - no translation maintenance while RAM off.
// - restore translation RAM power before enabling translation.
// - one rising clock edge times everything.
// - asynchronous inputs synchronised before use.
// - every port strictly input or output.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module cmp_pwr
  import cmp_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // RAM power switches.
  input wire logic [2:0] pwr_ack_i,
  output logic [2:0] pwr_sw_o,
  // Link to the memory system end.
  cmp_if.ctl lnk
);

  typedef struct packed {
    logic [2:0] ctrl;
    logic [2:0] preq;
    cmp_ps_t [2:0] ps;
    logic [2:0] sw;
    logic [2:0] pwr;
    logic [2:0] ack_s1;
    logic [2:0] ack_s2;
    logic [10:0] refuse;
    logic c1_wr;
    logic [2:0] c1_en;
    logic [2:0] mnt_req;
    logic mnt_inv;
    logic [31:0] rdata;
  } cmp_pwr_t;

  cmp_pwr_t st_r;
  cmp_pwr_t st_nxt;

  logic wr_ctrl;
  logic wr_pwr;
  logic wr_maint;
  logic wr_ref;

  assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
  assign wr_pwr = wr_i && (addr_i == OFS_PWR);
  assign wr_maint = wr_i && (addr_i == OFS_MAINT);
  assign wr_ref = wr_i && (addr_i == OFS_REFUSE);

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    logic on;
    logic may_off;
    logic go_down;
    logic go_up;
    on = 1'b0;
    may_off = 1'b0;
    go_down = 1'b0;
    go_up = 1'b0;
    st_nxt = st_r;
    st_nxt.ack_s1 = pwr_ack_i;
    st_nxt.ack_s2 = st_r.ack_s1;
    st_nxt.c1_wr = wr_ctrl;
    st_nxt.mnt_req = 3'h0;
    st_nxt.mnt_inv = 1'b0;
    if (wr_maint) begin
      st_nxt.mnt_inv = wdata_i[MAINT_INV_BIT];
    end
    for (int i = 0; i < NARR; i++) begin
      on = (st_r.ps[i] == PS_ON);
      may_off = on && !lnk.en[i] && lnk.empty[i] && !st_r.ctrl[i] && !st_r.c1_wr &&
                (st_r.mnt_req[i] == 1'b0);
      go_down = 1'b0;
      go_up = 1'b0;
      if (wr_ctrl) begin
        if (wdata_i[i] && !on) begin
          st_nxt.refuse[REF_EN_LSB + i] = 1'b1;
        end else begin
          st_nxt.ctrl[i] = wdata_i[i];
        end
      end
      if (wr_maint && wdata_i[i]) begin
        if (on) begin
          st_nxt.mnt_req[i] = 1'b1;
        end else begin
          st_nxt.refuse[REF_MAINT_LSB + i] = 1'b1;
        end
      end
      if (wr_pwr) begin
        if (!wdata_i[i] && st_r.preq[i]) begin
          if (may_off && !(wr_ctrl && wdata_i[i]) && !(wr_maint && wdata_i[i])) begin
            st_nxt.preq[i] = 1'b0;
            go_down = 1'b1;
          end else begin
            st_nxt.refuse[REF_OFF_LSB + i] = 1'b1;
          end
        end else if (wdata_i[i] && !st_r.preq[i]) begin
          st_nxt.preq[i] = 1'b1;
          go_up = 1'b1;
        end
      end
      unique case (st_r.ps[i])
        PS_ON: begin
          if (go_down) begin
            st_nxt.ps[i] = PS_DOWN;
            st_nxt.sw[i] = 1'b0;
          end
        end
        PS_DOWN: begin
          if (!st_r.ack_s2[i]) begin
            st_nxt.ps[i] = PS_OFF;
          end
        end
        PS_OFF: begin
          if (st_r.preq[i]) begin
            st_nxt.ps[i] = PS_UP;
            st_nxt.sw[i] = 1'b1;
          end
        end
        PS_UP: begin
          if (st_r.ack_s2[i]) begin
            st_nxt.ps[i] = PS_ON;
          end
        end
      endcase
      if (go_up && st_r.ps[i] == PS_ON) begin
        st_nxt.ps[i] = PS_ON;
      end
      st_nxt.pwr[i] = (st_nxt.ps[i] == PS_ON);
    end
    st_nxt.c1_en = st_nxt.ctrl;
    if (wr_ref) begin
      for (int b = 0; b < 11; b++) begin
        if (wdata_i[b] && (st_nxt.refuse[b] == st_r.refuse[b])) begin
          st_nxt.refuse[b] = 1'b0;
        end
      end
    end
    st_nxt.rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        OFS_CTRL: st_nxt.rdata[2:0] = st_r.ctrl;
        OFS_PWR: st_nxt.rdata[2:0] = st_r.preq;
        OFS_STAT: begin
          st_nxt.rdata[STAT_PWR_LSB +: 3] = st_r.pwr;
          st_nxt.rdata[STAT_EN_LSB +: 3] = lnk.en;
          st_nxt.rdata[STAT_EMPTY_LSB +: 3] = lnk.empty;
        end
        OFS_REFUSE: st_nxt.rdata[10:0] = st_r.refuse;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.preq <= PWR_RST;
      st_r.ps <= {PS_ON, PS_ON, PS_ON};
      st_r.sw <= PWR_RST;
      st_r.pwr <= PWR_RST;
      st_r.c1_en <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign rdata_o = st_r.rdata;
  assign pwr_sw_o = st_r.sw;
  assign lnk.c1_wr = st_r.c1_wr;
  assign lnk.c1_en = st_r.c1_en;
  assign lnk.mnt_req = st_r.mnt_req;
  assign lnk.mnt_inv = st_r.mnt_inv;
  assign lnk.ram_pwr = st_r.pwr;

endmodule

// File: tb/cmp_asserts.sv
// Link checker for the cache and translation RAM power gate.
`timescale 1ns/100ps
module cmp_asserts (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic c1_wr,
  input wire logic [2:0] c1_en,
  input wire logic [2:0] mnt_req,
  input wire logic mnt_inv,
  input wire logic [2:0] ram_pwr,
  input wire logic [2:0] en,
  input wire logic [2:0] empty,
  input wire logic [2:0] mnt_ack
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  chk_off_when_idle: assert property
    ((~ram_pwr & $past(ram_pwr) & ($past(en) | ~$past(empty))) == 3'h0) else $error("busy off");
  chk_req_powered: assert property
    ((mnt_req & ~ram_pwr) == 3'h0) else $error("maint unpowered");
  chk_en_powered: assert property
    ((en & ~ram_pwr) == 3'h0) else $error("enabled unpowered");
  chk_ack_cause: assert property
    (mnt_ack == ($past(mnt_req) & $past(ram_pwr))) else $error("ack mismatch");
  chk_en_update: assert property
    (c1_wr |=> en == $past(c1_en)) else $error("enable not taken");
  chk_en_hold: assert property
    (!c1_wr |=> $stable(en)) else $error("enable moved");
  chk_inv_empties: assert property
    ((mnt_inv && (mnt_req & ram_pwr) != 3'h0) |=> (empty & $past(mnt_req)) == $past(mnt_req))
    else $error("entries left");
  chk_fill_needs_en: assert property
    (($past(empty) & ~empty & ~($past(en) & $past(ram_pwr))) == 3'h0) else $error("fill off");
endmodule

// File: tb/cache_mmu_ram_power_gate_bench.sv
// Bench joining both ends of the cache and translation RAM power gate.
`timescale 1ns/100ps
module cache_mmu_ram_power_gate_bench;
  import cmp_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0] ack = 3'h7;
  logic [2:0] sw;
  logic [2:0] lookup = 3'h0;
  logic [2:0] fill = 3'h0;
  logic [2:0] fclr = 3'h0;
  logic [2:0] cs;
  logic [2:0] rpw;
  logic [2:0] en_out;
  logic [2:0] flt;
  int n_fail = 0;
  int checks_done = 0;
  cmp_if cmp_if_inst ();
  cmp_dev cmp_dev_inst (.clock_i(clock_i), .rstn_i(rstn_i), .lnk(cmp_if_inst.dev),
    .lookup_i(lookup), .fill_i(fill), .fault_clr_i(fclr), .ram_cs_o(cs), .ram_pwr_o(rpw),
    .en_o(en_out), .fault_o(flt));
  cmp_pwr cmp_pwr_inst (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pwr_ack_i(ack), .pwr_sw_o(sw),
    .lnk(cmp_if_inst.ctl));
  cmp_asserts cmp_asserts_inst (.clock_i(clock_i), .rstn_i(rstn_i), .c1_wr(cmp_if_inst.c1_wr),
    .c1_en(cmp_if_inst.c1_en), .mnt_req(cmp_if_inst.mnt_req), .mnt_inv(cmp_if_inst.mnt_inv),
    .ram_pwr(cmp_if_inst.ram_pwr), .en(cmp_if_inst.en), .empty(cmp_if_inst.empty),
    .mnt_ack(cmp_if_inst.mnt_ack));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  // The power switches follow their command one cycle late.
  always @(posedge clock_i) ack <= sw;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clock_i);
  endtask
  task automatic wait_pwr(input logic [2:0] m);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      #1;
      if (rpw === m) break;
    end
    chk({29'h0, rpw}, {29'h0, m});
    if (rpw !== m) begin
      stop_test();
    end else begin
      @(posedge clock_i);
    end
  endtask
  task automatic chk_pins(input logic [2:0] e);
    @(negedge clock_i);
    chk({29'h0, en_out}, {29'h0, e});
    chk({29'h0, flt}, 32'h0);
    @(posedge clock_i);
  endtask
  task automatic t_cache();
    wr_reg(OFS_CTRL, 32'h1);
    repeat (2) @(posedge clock_i);
    fill <= 3'h1;
    @(posedge clock_i);
    fill <= 3'h0;
    wr_reg(OFS_PWR, 32'h6);
    wr_reg(OFS_CTRL, 32'h0);
    repeat (2) @(posedge clock_i);
    wr_reg(OFS_PWR, 32'h6);
    rd_reg(OFS_REFUSE, 32'h100);
    lookup <= 3'h1;
    repeat (2) @(negedge clock_i);
    chk({29'h0, cs}, 32'h0);
    @(posedge clock_i);
    wr_reg(OFS_MAINT, 32'h9);
    @(negedge clock_i);
    chk({29'h0, cs}, 32'h1);
    chk({29'h0, cmp_if_inst.mnt_ack}, 32'h1);
    @(posedge clock_i);
    lookup <= 3'h0;
    wr_reg(OFS_REFUSE, 32'h7FF);
    wr_reg(OFS_PWR, 32'h6);
    wait_pwr(3'h6);
    wr_reg(OFS_MAINT, 32'h1);
    wr_reg(OFS_CTRL, 32'h1);
    rd_reg(OFS_REFUSE, 32'h11);
    rd_reg(OFS_STAT, 32'h706);
    chk_pins(3'h0);
    wr_reg(OFS_PWR, 32'h7);
    wait_pwr(3'h7);
    wr_reg(OFS_CTRL, 32'h1);
    rd_reg(OFS_STAT, 32'h717);
    chk_pins(3'h1);
  endtask
  task automatic t_xlate();
    fill <= 3'h4;
    @(posedge clock_i);
    fill <= 3'h0;
    wr_reg(OFS_REFUSE, 32'h7FF);
    wr_reg(OFS_PWR, 32'h3);
    wait_pwr(3'h3);
    wr_reg(OFS_MAINT, 32'h4);
    wr_reg(OFS_CTRL, 32'h5);
    rd_reg(OFS_REFUSE, 32'h44);
    rd_reg(OFS_STAT, 32'h713);
    chk_pins(3'h1);
    wr_reg(OFS_PWR, 32'h7);
    wait_pwr(3'h7);
    wr_reg(OFS_CTRL, 32'h5);
    rd_reg(OFS_STAT, 32'h757);
    chk_pins(3'h5);
  endtask
  task automatic t_reset();
    rd_reg(OFS_STAT, 32'h707);
    rd_reg(OFS_PWR, 32'h7);
    chk_pins(3'h0);
  endtask
  task automatic stop_test();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_cache();
    t_xlate();
    stop_test();
  end
endmodule
